/* tb/cmt_engine_model.sv */
// Protocol engine stand-in facing the unit's frame request port.
// Assumes txReq and its fields stand until txDone or txAbort is seen.
`timescale 1ns/1ps
`default_nettype none
module cmt_engine_model (
    input wire logic clk,
    input wire logic txReq,
    input wire logic [28:0] txId,
    input wire logic txRtr,
    input wire logic [7:0] lat,
    input wire logic [3:0] abortAt,
    output logic txDone,
    output logic txAbort
);
    logic [29:0] sent[$];
    // Latency is set by the bench so the scheduler sees slow answers.
    initial begin
        txDone = 0;
        txAbort = 0;
        forever begin
            @(posedge clk);
            if (txReq === 1'b1) begin
                sent.push_back({txRtr, txId});
                repeat (lat) @(posedge clk);
                txDone <= sent.size() != abortAt;
                txAbort <= sent.size() == abortAt;
                @(posedge clk);
                txDone <= 0;
                txAbort <= 0;
                @(posedge clk);
            end
        end
    end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the mailbox and timer unit.
// Assumes the engine model answers frame requests on the far side.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, irq, err, txReq, txIde, txRtr, txDone, txAbort;
    logic bitTick = 0, sofPulse = 0, eofPulse = 0, rxValid = 0, rxRtr = 0;
    logic rxIde = 1;
    logic [28:0] rxId = 0, txId, id, ids[4];
    logic [28:0] mask = 29'h1fff_ffe3;
    logic [3:0] rxDlc = 8, txDlc, abortAt = 3;
    logic [63:0] rxData = 0, txData, d[4];
    logic [7:0] lat = 20;
    int numErrors = 0, totalChecks = 0, cyc = 0, k;
    always #5 clk = ~clk;
    cmt_mailbox_unit i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .bitTick, .sofPulse,
        .eofPulse, .rxValid, .rxId, .rxIde, .rxRtr, .rxDlc, .rxData,
        .txReq, .txId, .txIde, .txRtr, .txDlc, .txData, .txDone, .txAbort);
    cmt_engine_model i_eng (.clk, .txReq, .txId, .txRtr, .lat, .abortAt,
        .txDone, .txAbort);
    task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    function automatic logic [11:0] mba(int x, logic [2:0] g);
        return 12'h200 + 12'(x) * 12'h20 + 12'(g) * 12'h4;
    endfunction
    function automatic logic [31:0] fam(logic [28:0] i, logic [28:0] m);
        int n;
        fam = 0;
        n = 0;
        for (int b = 0; b < 29; b++) begin
            if (!m[b]) begin
                fam[n] = i[b];
                n++;
            end
        end
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ticks(int n);
        bitTick <= 1;
        repeat (n) @(posedge clk);
        bitTick <= 0;
        @(posedge clk);
    endtask
    task automatic frame(logic [28:0] i, logic [63:0] dd);
        rxValid <= 1;
        rxId <= i;
        rxData <= dd;
        @(posedge clk);
        rxValid <= 0;
        @(posedge clk);
    endtask
    // Waits until n frames have gone out and the request line is idle.
    task automatic drain(int n);
        k = 0;
        while ((i_eng.sent.size() < n || txReq) && k < 400) begin
            if (txReq === 1'b1 && txId == 29'h3)
                chk({txIde, 3'h0, txDlc, txData[23:0]},
                    {1'b1, 3'h0, 4'h8, d[0][23:0]});
            @(posedge clk);
            k++;
        end
        if (k == 400)
            numErrors++;
    endtask
    task automatic testDone;
        $display("checks %0d mismatches %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            numErrors++;
            testDone;
        end
    end
    initial begin
        void'($urandom(18));
        repeat (8) @(posedge clk);
        rst <= 0;
        apb(0, 12'h018, 0);
        chk({r[30:0], err}, 1);
        apb(1, cmt_pkg::OFS_MR, 1);
        k = $urandom_range(40, 1);
        ticks(k);
        apb(0, cmt_pkg::OFS_TIM, 0);
        chk(r, k);
        apb(1, cmt_pkg::OFS_TCR, 32'h8000_0000);
        apb(0, cmt_pkg::OFS_TIM, 0);
        chk(r, 0);
        ticks(3);
        apb(1, cmt_pkg::OFS_MR, 0);
        ticks(2);
        apb(0, cmt_pkg::OFS_TIM, 0);
        chk(r, 0);
        $display("test timer done");
        // The unselected frame edge comes first and must not capture.
        for (int m = 0; m < 2; m++) begin
            apb(1, cmt_pkg::OFS_MR, 1 | (m << 6));
            apb(1, cmt_pkg::OFS_TCR, 32'h8000_0000);
            ticks(5);
            sofPulse <= m == 1;
            eofPulse <= m == 0;
            ticks(3);
            sofPulse <= m == 0;
            eofPulse <= m == 1;
            @(posedge clk);
            sofPulse <= 0;
            eofPulse <= 0;
            apb(0, cmt_pkg::OFS_TIMESTAMP_FLAG, 0);
            chk(r, 8);
            apb(0, cmt_pkg::OFS_SR, 0);
            chk(r, 2);
            apb(0, cmt_pkg::OFS_SR, 0);
            chk(r, 0);
        end
        // A frame edge during the status read must survive the read.
        eofPulse <= 1;
        @(posedge clk);
        fork
            apb(0, cmt_pkg::OFS_SR, 0);
            begin
                repeat (2) @(posedge clk);
                eofPulse <= 0;
            end
        join
        apb(0, cmt_pkg::OFS_SR, 0);
        chk(r, 2);
        $display("test timestamp done");
        apb(1, cmt_pkg::OFS_IMR, 1);
        apb(1, cmt_pkg::OFS_MR, 32'h81);
        apb(1, cmt_pkg::OFS_TCR, 32'h8000_0000);
        ticks(65539);
        apb(0, cmt_pkg::OFS_TIM, 0);
        chk(r, 32'hffff);
        chk(32'(irq), 1);
        apb(0, cmt_pkg::OFS_SR, 0);
        chk(r, 1);
        chk(32'(irq), 0);
        apb(1, cmt_pkg::OFS_TCR, 32'h8000_0000);
        ticks(2);
        apb(0, cmt_pkg::OFS_TIM, 0);
        chk(r, 2);
        $display("test freeze done");
        apb(1, cmt_pkg::OFS_MR, 1);
        id = 29'($urandom);
        for (int x = 0; x < 3; x++) begin
            apb(1, mba(x, cmt_pkg::MB_MMR), {5'h0, x == 2 ? 3'h2 : 3'h1, 24'h0});
            apb(1, mba(x, cmt_pkg::MB_MAM), {3'h0, mask});
            apb(1, mba(x, cmt_pkg::MB_MID), {3'h1, id});
        end
        for (int f = 0; f < 4; f++) begin
            ids[f] = id ^ 29'($urandom_range(7) << 2);
            d[f] = {$urandom, $urandom};
            frame(ids[f], d[f]);
        end
        frame(id ^ 29'h1000_0000, 0);
        rxIde <= 0;
        frame(id, 0);
        rxIde <= 1;
        apb(0, mba(0, cmt_pkg::MB_MID), 0);
        chk(r, {3'h1, ids[0]});
        apb(0, mba(0, cmt_pkg::MB_MFID), 0);
        chk(r, fam(ids[0], mask));
        apb(0, mba(0, cmt_pkg::MB_MDL), 0);
        chk(r, d[0][31:0]);
        apb(0, mba(0, cmt_pkg::MB_MSR), 0);
        chk(32'(r[23]), 1);
        apb(0, mba(1, cmt_pkg::MB_MDL), 0);
        chk(r, d[1][31:0]);
        apb(0, mba(2, cmt_pkg::MB_MDH), 0);
        chk(r, d[3][63:32]);
        apb(0, mba(2, cmt_pkg::MB_MDL), 0);
        chk(r, d[3][31:0]);
        apb(0, mba(2, cmt_pkg::MB_MSR), 0);
        chk(32'(r[23]), 1);
        $display("test receive done");
        lat = 8'($urandom_range(40, 24));
        for (int x = 3; x < 7; x++) begin
            k = x == 6 ? 15 : x == 4 ? 2 : x + 2;
            apb(1, mba(x, cmt_pkg::MB_MMR),
                {5'h0, x == 6 ? 3'h3 : 3'h4, 4'h0, 4'(k), 16'h0});
            apb(1, mba(x, cmt_pkg::MB_MID), {3'h1, 29'(x)});
        end
        d[0] = {$urandom, $urandom};
        apb(1, mba(3, cmt_pkg::MB_MDL), d[0][31:0]);
        // Lower priority is requested before higher while mailbox 3 is busy.
        foreach (ids[i]) apb(1, mba(i == 0 ? 3 : 7 - i, 7), 32'h0088_0000);
        drain(4);
        for (int i = 0; i < 4; i++)
            chk(32'(i_eng.sent[i]), {i == 3, 29'(i == 3 ? 6 : i + 3)});
        apb(0, mba(5, cmt_pkg::MB_MSR), 0);
        chk(32'(r[22]), 1);
        apb(0, mba(4, cmt_pkg::MB_MSR), 0);
        chk(32'(r[23]), 1);
        for (int f = 1; f < 3; f++) begin
            d[f] = {$urandom, $urandom};
            frame(29'h6, d[f]);
        end
        apb(0, mba(6, cmt_pkg::MB_MDL), 0);
        chk(r, d[1][31:0]);
        apb(1, mba(7, cmt_pkg::MB_MMR), 32'h0500_0000);
        apb(1, mba(7, cmt_pkg::MB_MID), {3'h1, 29'h7});
        rxRtr <= 1;
        frame(29'h7, 0);
        rxRtr <= 0;
        drain(5);
        chk(32'(i_eng.sent[4]), 32'h7);
        // Time-triggered: mailbox 4 waits for the timer to reach 16.
        apb(1, cmt_pkg::OFS_MR, 32'h21);
        apb(1, mba(4, cmt_pkg::MB_MMR), 32'h0402_0010);
        apb(1, cmt_pkg::OFS_TCR, 32'h8000_0000);
        apb(1, mba(4, 7), 32'h0088_0000);
        ticks(8);
        chk(32'(txReq), 0);
        ticks(20);
        drain(6);
        chk(32'(i_eng.sent[5]), 32'h4);
        $display("test transmit done");
        testDone;
    end
endmodule
`default_nettype wire

/* verilog/cmt_accept_filter.sv */
// Acceptance filter: mask-and-compare per mailbox plus family index.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
module cmt_accept_filter #(
    parameter int N = cmt_pkg::NUM_MB
) (
    input wire logic [cmt_pkg::ID_W-1:0] rxId,
    input wire logic rxIde,
    input wire logic [N-1:0][cmt_pkg::ID_W-1:0] mbId,
    input wire logic [N-1:0] mbIde,
    input wire logic [N-1:0][cmt_pkg::ID_W-1:0] mbMask,
    output logic [N-1:0] hit,
    output logic [N-1:0][cmt_pkg::ID_W-1:0] family
);
    // Standard identifiers live in the top eleven bits.
    function automatic logic [cmt_pkg::ID_W-1:0] validBits(input logic ide);
        validBits = '1;
        if (!ide) begin
            validBits[cmt_pkg::STD_LSB-1:0] = '0;
        end
    endfunction

    // Packs the don't-care identifier bits, right-justified.
    function automatic logic [cmt_pkg::ID_W-1:0] compact(
        input logic [cmt_pkg::ID_W-1:0] id,
        input logic [cmt_pkg::ID_W-1:0] sel);
        logic [cmt_pkg::ID_W-1:0] r;
        int k;
        r = '0;
        k = 0;
        for (int b = 0; b < cmt_pkg::ID_W; b++) begin
            if (sel[b]) begin
                r[k] = id[b];
                k++;
            end
        end
        compact = r;
    endfunction

    always_comb begin
        for (int i = 0; i < N; i++) begin
            hit[i] = (rxIde == mbIde[i]) &&
                (((rxId ^ mbId[i]) & mbMask[i] & validBits(mbIde[i]))
                 == '0);
            family[i] = compact(rxId,
                ~mbMask[i] & validBits(mbIde[i]));
        end
    end
endmodule
`default_nettype wire

/* verilog/cmt_mailbox_unit.sv */
// Mailbox store, receive selection, transmit scheduler and time unit.
// Assumes an APB master on one side and a protocol engine that delivers
// decoded frames and takes frame requests on the other.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cmt_mailbox_unit #(
    parameter int N = cmt_pkg::NUM_MB
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic bitTick,
    input wire logic sofPulse,
    input wire logic eofPulse,
    input wire logic rxValid,
    input wire logic [cmt_pkg::ID_W-1:0] rxId,
    input wire logic rxIde,
    input wire logic rxRtr,
    input wire logic [3:0] rxDlc,
    input wire logic [63:0] rxData,
    output logic txReq,
    output logic [cmt_pkg::ID_W-1:0] txId,
    output logic txIde,
    output logic txRtr,
    output logic [3:0] txDlc,
    output logic [63:0] txData,
    input wire logic txDone,
    input wire logic txAbort
);
    localparam int IW = cmt_pkg::ID_W;

    typedef struct packed {
        logic [7:0] mr;
        logic [1:0] imr;
        logic timer_overflow_flag;
        logic timestamp_flag;
        logic [15:0] stamp;
        logic [31:0] rdata;
        logic lpPrev;
        logic lastPrev;
        logic [N-1:0][2:0] mailbox_object_type;
        logic [N-1:0][3:0] rank;
        logic [N-1:0][15:0] trig;
        logic [N-1:0][IW-1:0] mask;
        logic [N-1:0][IW-1:0] id;
        logic [N-1:0] ide;
        logic [N-1:0][IW-1:0] fam;
        logic [N-1:0][63:0] data;
        logic [N-1:0][3:0] dlc;
        logic [N-1:0] mailbox_message_ready;
        logic [N-1:0] abort;
        logic [N-1:0] pend;
        logic [N-1:0] fired;
        logic [N-1:0] ansWait;
        logic busy;
        logic [3:0] sel;
        logic txRtr;
    } cmt_mbu_s;
    cmt_mbu_s st;
    cmt_mbu_s next_st;

    logic [N-1:0] hit;
    logic [N-1:0][IW-1:0] family;
    logic [15:0] tmCount;
    logic tmWrap;
    logic tmClear;
    logic [N-1:0] avail;
    logic [N-1:0] elig;
    logic [3:0] rxWin;
    logic rxFound;
    logic [3:0] txBest;
    logic access;
    logic setup;
    logic [3:0] mbIdx;
    logic [2:0] mbReg;
    logic inMb;
    logic mapped;
    logic srRead;
    logic timWrite;
    logic stampEvt;

    assign access = psel && penable;
    assign setup = psel && !penable;
    assign inMb = paddr[11:9] == cmt_pkg::MB_REGION;
    assign mbIdx = paddr[8:5];
    assign mbReg = paddr[4:2];
    assign mapped = inMb || paddr == cmt_pkg::OFS_MR ||
        paddr == cmt_pkg::OFS_IMR || paddr == cmt_pkg::OFS_SR ||
        paddr == cmt_pkg::OFS_TCR || paddr == cmt_pkg::OFS_TIM ||
        paddr == cmt_pkg::OFS_TIMESTAMP_FLAG;
    assign srRead = access && !pwrite && paddr == cmt_pkg::OFS_SR;
    assign timWrite = access && pwrite && paddr == cmt_pkg::OFS_TCR &&
        pwdata[cmt_pkg::TCR_TIMER_CLEAR_COMMAND];
    assign stampEvt = st.mr[cmt_pkg::MR_CAPTURE_AT_FRAME_END] ? eofPulse : sofPulse;

    // Timer clears: software, low-power entry, disable, last mailbox ready in TTM mode.
    assign tmClear = timWrite ||
        (st.mr[cmt_pkg::MR_LOWPWR] && !st.lpPrev) ||
        !st.mr[cmt_pkg::MR_CONTROLLER_ENABLE] ||
        (st.mr[cmt_pkg::MR_TTM] && st.mailbox_message_ready[N-1] && !st.lastPrev);

    cmt_accept_filter #(.N(N)) u_filter (
        .rxId(rxId),
        .rxIde(rxIde),
        .mbId(st.id),
        .mbIde(st.ide),
        .mbMask(st.mask),
        .hit(hit),
        .family(family)
    );

    cmt_timer u_timer (
        .clk(clk),
        .rst(rst),
        .tick(bitTick),
        .run(st.mr[cmt_pkg::MR_CONTROLLER_ENABLE]),
        .clear(tmClear),
        .freeze(st.mr[cmt_pkg::MR_TIMER_FREEZE_ENABLE]),
        .count(tmCount),
        .wrap(tmWrap)
    );

    // Receive availability, lowest index first.
    always_comb begin
        rxFound = 1'b0;
        rxWin = 4'h0;
        for (int i = 0; i < N; i++) begin
            case (st.mailbox_object_type[i])
                cmt_pkg::CMT_MOT_RX: avail[i] = !st.mailbox_message_ready[i];
                cmt_pkg::CMT_MOT_RXOVR: avail[i] = 1'b1;
                cmt_pkg::CMT_MOT_CONSUMER:
                    avail[i] = st.ansWait[i] && !st.mailbox_message_ready[i];
                default: avail[i] = 1'b0;
            endcase
        end
        for (int i = N - 1; i >= 0; i--) begin
            if (hit[i] && avail[i]) begin
                rxFound = 1'b1;
                rxWin = 4'(i);
            end
        end
    end

    // Smaller rank value wins; ties go to the lower index.
    always_comb begin
        txBest = 4'h0;
        for (int i = 0; i < N; i++) begin
            elig[i] = st.pend[i] && st.mr[cmt_pkg::MR_CONTROLLER_ENABLE] &&
                (!st.mr[cmt_pkg::MR_TTM] || st.fired[i]);
        end
        for (int i = N - 1; i >= 0; i--) begin
            if (elig[i] && (!elig[txBest] ||
                st.rank[i] <= st.rank[txBest])) begin
                txBest = 4'(i);
            end
        end
    end

    function automatic logic [31:0] readMux(input cmt_mbu_s s,
        input logic [11:0] a, input logic [15:0] tim);
        logic [3:0] x;
        x = a[8:5];
        readMux = 32'h0000_0000;
        if (a[11:9] == cmt_pkg::MB_REGION) begin
            case (a[4:2])
                cmt_pkg::MB_MMR: readMux = {5'h00, s.mailbox_object_type[x], 4'h0,
                    s.rank[x], s.trig[x]};
                cmt_pkg::MB_MAM: readMux = {3'h0, s.mask[x]};
                cmt_pkg::MB_MID: readMux = {2'h0, s.ide[x], s.id[x]};
                cmt_pkg::MB_MFID: readMux = {3'h0, s.fam[x]};
                cmt_pkg::MB_MDL: readMux = s.data[x][31:0];
                cmt_pkg::MB_MDH: readMux = s.data[x][63:32];
                cmt_pkg::MB_MSR: readMux = {8'h00, s.mailbox_message_ready[x],
                    s.abort[x], 2'h0, s.dlc[x], 16'h0000};
                default: readMux = 32'h0000_0000;
            endcase
        end else begin
            case (a)
                cmt_pkg::OFS_MR: readMux = {24'h000000, s.mr};
                cmt_pkg::OFS_IMR: readMux = {30'h0, s.imr};
                cmt_pkg::OFS_SR: readMux = {s.mailbox_message_ready, 14'h0000,
                    s.timestamp_flag, s.timer_overflow_flag};
                cmt_pkg::OFS_TIM: readMux = {16'h0000, tim};
                cmt_pkg::OFS_TIMESTAMP_FLAG: readMux = {16'h0000, s.stamp};
                default: readMux = 32'h0000_0000;
            endcase
        end
    endfunction

    always_comb begin
        next_st = st;
        next_st.lpPrev = st.mr[cmt_pkg::MR_LOWPWR];
        next_st.lastPrev = st.mailbox_message_ready[N-1];
        // Read data is sampled in the setup cycle, so only flags that
        // software actually saw are cleared by the status read.
        if (setup && !pwrite) begin
            next_st.rdata = readMux(st, paddr, tmCount);
        end
        next_st.timer_overflow_flag = (st.timer_overflow_flag && !(srRead && st.rdata[cmt_pkg::SR_TIMER_OVERFLOW_FLAG]))
            || tmWrap;
        next_st.timestamp_flag = (st.timestamp_flag && !(srRead && st.rdata[cmt_pkg::SR_TIMESTAMP_FLAG]))
            || stampEvt;
        if (stampEvt) begin
            next_st.stamp = tmCount;
        end
        for (int i = 0; i < N; i++) begin
            if (st.mr[cmt_pkg::MR_TTM] && st.pend[i] &&
                tmCount == st.trig[i]) begin
                next_st.fired[i] = 1'b1;
            end
        end
        if (access && pwrite && mapped) begin
            if (inMb) begin
                case (mbReg)
                    cmt_pkg::MB_MMR: begin
                        next_st.mailbox_object_type[mbIdx] = pwdata[26:24];
                        next_st.rank[mbIdx] = pwdata[19:16];
                        next_st.trig[mbIdx] = pwdata[15:0];
                    end
                    cmt_pkg::MB_MAM: next_st.mask[mbIdx] = pwdata[IW-1:0];
                    cmt_pkg::MB_MID: begin
                        next_st.id[mbIdx] = pwdata[IW-1:0];
                        next_st.ide[mbIdx] = pwdata[cmt_pkg::MID_IDE];
                    end
                    cmt_pkg::MB_MDL: next_st.data[mbIdx][31:0] = pwdata;
                    cmt_pkg::MB_MDH: next_st.data[mbIdx][63:32] = pwdata;
                    cmt_pkg::MB_MCR: begin
                        if (pwdata[cmt_pkg::MCR_REQ]) begin
                            next_st.mailbox_message_ready[mbIdx] = 1'b0;
                            next_st.abort[mbIdx] = 1'b0;
                            next_st.fired[mbIdx] = 1'b0;
                            next_st.dlc[mbIdx] = pwdata[19:16];
                            next_st.ansWait[mbIdx] = 1'b0;
                            next_st.pend[mbIdx] =
                                st.mailbox_object_type[mbIdx] == cmt_pkg::CMT_MOT_TX ||
                                st.mailbox_object_type[mbIdx] == cmt_pkg::CMT_MOT_CONSUMER;
                        end
                    end
                    default: next_st.mailbox_object_type[mbIdx] = st.mailbox_object_type[mbIdx];
                endcase
            end else if (paddr == cmt_pkg::OFS_MR) begin
                next_st.mr = pwdata[7:0];
            end else if (paddr == cmt_pkg::OFS_IMR) begin
                next_st.imr = pwdata[1:0];
            end
        end
        if (rxValid && rxRtr) begin
            for (int i = 0; i < N; i++) begin
                if (hit[i] && st.mailbox_object_type[i] == cmt_pkg::CMT_MOT_PRODUCER) begin
                    next_st.pend[i] = 1'b1;
                end
            end
        end else if (rxValid && rxFound) begin
            next_st.id[rxWin] = rxId;
            next_st.fam[rxWin] = family[rxWin];
            next_st.data[rxWin] = rxData;
            next_st.dlc[rxWin] = rxDlc;
            next_st.mailbox_message_ready[rxWin] = 1'b1;
            next_st.ansWait[rxWin] = 1'b0;
        end
        if (st.busy && (txDone || txAbort)) begin
            next_st.busy = 1'b0;
            next_st.pend[st.sel] = 1'b0;
            next_st.fired[st.sel] = 1'b0;
            if (txAbort) begin
                next_st.abort[st.sel] = 1'b1;
                next_st.mailbox_message_ready[st.sel] = 1'b1;
            end else if (st.txRtr) begin
                next_st.ansWait[st.sel] = 1'b1;
            end else begin
                next_st.mailbox_message_ready[st.sel] = 1'b1;
            end
        end else if (!st.busy && |elig) begin
            next_st.busy = 1'b1;
            next_st.sel = txBest;
            next_st.txRtr = st.mailbox_object_type[txBest] == cmt_pkg::CMT_MOT_CONSUMER;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Frame fields except txRtr are read straight from the held mailbox.
    assign txReq = st.busy;
    assign txId = st.id[st.sel];
    assign txIde = st.ide[st.sel];
    assign txRtr = st.txRtr;
    assign txDlc = st.dlc[st.sel];
    assign txData = st.data[st.sel];
    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign irq = |({st.timestamp_flag, st.timer_overflow_flag} & st.imr);

    AST_TIMER_OVERFLOW_FLAG_SET: assert property (@(posedge clk) disable iff (rst)
        tmWrap |=> st.timer_overflow_flag) else $error("overflow flag not set");
    AST_FLAG_KEEP: assert property (@(posedge clk) disable iff (rst)
        ((tmWrap || stampEvt) && srRead) |=>
        (st.timer_overflow_flag || !$past(tmWrap)) && (st.timestamp_flag || !$past(stampEvt)))
        else $error("flag lost on status read");
    AST_TIM_CLR: assert property (@(posedge clk) disable iff (rst)
        timWrite |=> tmCount == 16'h0000) else $error("timer not cleared");
    AST_TIM_OFF: assert property (@(posedge clk) disable iff (rst)
        !st.mr[cmt_pkg::MR_CONTROLLER_ENABLE] |=> tmCount == 16'h0000)
        else $error("timer runs while disabled");
    AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
        (st.mr[cmt_pkg::MR_TIMER_FREEZE_ENABLE] && tmCount == 16'hffff && !tmClear)
        |=> tmCount == 16'hffff) else $error("frozen timer moved");
    AST_STAMP: assert property (@(posedge clk) disable iff (rst)
        stampEvt |=> st.timestamp_flag && st.stamp == $past(tmCount))
        else $error("timestamp not captured");
    AST_RX_STORE: assert property (@(posedge clk) disable iff (rst)
        (rxValid && !rxRtr && rxFound) |=> st.mailbox_message_ready[$past(rxWin)] &&
        st.id[$past(rxWin)] == $past(rxId)) else $error("rx not stored");
    AST_RX_LOCK: assert property (@(posedge clk) disable iff (rst)
        (st.mailbox_object_type[0] == cmt_pkg::CMT_MOT_RX && st.mailbox_message_ready[0] && !(access && pwrite))
        |=> $stable(st.data[0])) else $error("locked mailbox changed");
    AST_TX_START: assert property (@(posedge clk) disable iff (rst)
        (!st.busy && |elig && !txDone && !txAbort) |=> txReq &&
        st.sel == $past(txBest)) else $error("transmit not started");
    AST_TX_NOTE: assert property (@(posedge clk) disable iff (rst)
        (st.busy && txDone && !st.txRtr) |=> st.mailbox_message_ready[$past(st.sel)])
        else $error("completion not reported");
    CV_RX: cover property (@(posedge clk) rxValid && rxFound);
    CV_TX: cover property (@(posedge clk) txReq && txDone);
    CV_OVF: cover property (@(posedge clk) tmWrap);
    CV_STAMP: cover property (@(posedge clk) stampEvt);
endmodule
`default_nettype wire

/* verilog/cmt_pkg.sv */
// Constants and types shared by the mailbox and timer unit.
// Assumes a 32-bit APB slave with byte addresses in paddr.
package cmt_pkg;
    localparam int NUM_MB = 16;
    localparam int ID_W = 29;
    localparam int STD_LSB = 18;
    localparam int TIM_W = 16;
    localparam logic [15:0] TIMER_MAX = 16'hffff;
    localparam logic [15:0] TIMER_ZERO = 16'h0000;
    // Global registers, byte offsets.
    localparam logic [11:0] OFS_MR = 12'h000;
    localparam logic [11:0] OFS_IMR = 12'h004;
    localparam logic [11:0] OFS_SR = 12'h008;
    localparam logic [11:0] OFS_TCR = 12'h00c;
    localparam logic [11:0] OFS_TIM = 12'h010;
    localparam logic [11:0] OFS_TIMESTAMP_FLAG = 12'h014;
    // Mailbox x sits at 0x200 + x * 0x20, word index in paddr[4:2].
    localparam logic [2:0] MB_REGION = 3'h1;
    localparam logic [2:0] MB_MMR = 3'h0;
    localparam logic [2:0] MB_MAM = 3'h1;
    localparam logic [2:0] MB_MID = 3'h2;
    localparam logic [2:0] MB_MFID = 3'h3;
    localparam logic [2:0] MB_MDL = 3'h4;
    localparam logic [2:0] MB_MDH = 3'h5;
    localparam logic [2:0] MB_MSR = 3'h6;
    localparam logic [2:0] MB_MCR = 3'h7;
    // Field positions.
    localparam int MR_CONTROLLER_ENABLE = 0;
    localparam int MR_LOWPWR = 1;
    localparam int MR_TTM = 5;
    localparam int MR_CAPTURE_AT_FRAME_END = 6;
    localparam int MR_TIMER_FREEZE_ENABLE = 7;
    localparam int SR_TIMER_OVERFLOW_FLAG = 0;
    localparam int SR_TIMESTAMP_FLAG = 1;
    localparam int SR_MAILBOX_MESSAGE_READY_LSB = 16;
    localparam int TCR_TIMER_CLEAR_COMMAND = 31;
    localparam int MMR_RANK_LSB = 16;
    localparam int MMR_MOT_LSB = 24;
    localparam int MID_IDE = 29;
    localparam int MSR_DLC_LSB = 16;
    localparam int MSR_ABORT = 22;
    localparam int MSR_MAILBOX_MESSAGE_READY = 23;
    localparam int MCR_REQ = 23;
    typedef enum logic [2:0] {
        CMT_MOT_OFF = 3'b000,
        CMT_MOT_RX = 3'b001,
        CMT_MOT_RXOVR = 3'b010,
        CMT_MOT_CONSUMER = 3'b011,
        CMT_MOT_TX = 3'b100,
        CMT_MOT_PRODUCER = 3'b101
    } cmt_mot_e;
endpackage

/* verilog/cmt_timer.sv */
// Sixteen-bit timer advanced by a one-cycle bit clock tick.
// Assumes tick is a pulse synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module cmt_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic run,
    input wire logic clear,
    input wire logic freeze,
    output logic [cmt_pkg::TIM_W-1:0] count,
    output logic wrap
);
    typedef struct packed {
        logic [cmt_pkg::TIM_W-1:0] count;
        logic wrap;
    } cmt_tim_s;
    cmt_tim_s st;
    cmt_tim_s next_st;

    always_comb begin
        next_st = st;
        next_st.wrap = 1'b0;
        if (clear || !run) begin
            next_st.count = cmt_pkg::TIMER_ZERO;
        end else if (tick) begin
            if (freeze && st.count == cmt_pkg::TIMER_MAX) begin
                next_st.count = st.count;
            end else begin
                next_st.count = st.count + 16'h0001;
                // Frozen counters report overflow on reaching the top.
                next_st.wrap = freeze ?
                    (st.count == cmt_pkg::TIMER_MAX - 16'h0001) :
                    (st.count == cmt_pkg::TIMER_MAX);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;
    assign wrap = st.wrap;
endmodule
`default_nettype wire
